// [sim/drap_asserts.sv]
`timescale 1ns/1ps
module drap_asserts
  import drap_pkg::*;
(
  input wire logic              CORE_CLK_I,
  input wire logic              RESET_I,
  input wire logic              SERIAL_MODE_I,
  input wire logic [DATA_W-1:0] HOST_RDATA_O,
  input wire logic              HOST_RDATA_VALID_O,
  input wire logic              HOST_REFUSED_O,
  input wire logic              RAM_VALID_O,
  input wire logic              RAM_READY_I,
  input wire logic              RAM_WRITE_O,
  input wire logic [PAGE_W-1:0] RAM_PAGE_O,
  input wire logic [COL_W-1:0]  RAM_COL_O,
  input wire logic [DATA_W-1:0] RAM_WDATA_O,
  input wire logic [DATA_W-1:0] RAM_RDATA_I,
  input wire logic              CLEAR_BUSY_O,
  input wire logic [PAGE_W-1:0] PAGE_O,
  input wire logic [COL_W-1:0]  COLUMN_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  // Last sweep write rises in the same cycle as the busy flag drops
  sequence s_new_req;
    $rose(RAM_VALID_O) && !$past(CLEAR_BUSY_O);
  endsequence
  sequence s_rd_take;
    RAM_VALID_O && RAM_READY_I && !RAM_WRITE_O;
  endsequence
  sequence s_sweep;
    RAM_VALID_O && CLEAR_BUSY_O;
  endsequence
  a_reset_zero: assert property (
    $past(RESET_I) |-> PAGE_O == PAGE_RESET && COLUMN_O == COL_RESET
      && !RAM_VALID_O) else $error("pointers not zero after reset");
  a_col_step: assert property (
    s_new_req |-> COLUMN_O == ((RAM_COL_O >= COL_LAST) ? COL_RESET
      : RAM_COL_O + COL_ONE)) else $error("column step wrong");
  a_page_kept: assert property (
    s_new_req |-> RAM_PAGE_O == PAGE_O) else $error("page moved");
  a_req_hold: assert property (
    RAM_VALID_O && !RAM_READY_I |=> RAM_VALID_O && $stable(RAM_COL_O)
      && $stable(RAM_WDATA_O)) else $error("request dropped");
  a_read_data: assert property (
    s_rd_take |=> HOST_RDATA_VALID_O
      && HOST_RDATA_O == $past(RAM_RDATA_I)) else $error("bad read");
  a_serial_noread: assert property (
    $rose(RAM_VALID_O) && !RAM_WRITE_O |-> !$past(SERIAL_MODE_I))
    else $error("serial read reached RAM");
  a_refuse_still: assert property (
    HOST_REFUSED_O |-> COLUMN_O == $past(COLUMN_O) && !RAM_VALID_O)
    else $error("refused access moved column");
  a_clear_zero: assert property (
    s_sweep |-> RAM_WRITE_O && RAM_WDATA_O == CLEAR_DATA)
    else $error("sweep not writing zero");
  a_clear_area: assert property (
    s_sweep |-> RAM_COL_O <= COL_LAST && (RAM_PAGE_O <= GFX_PAGE_LAST
      || RAM_PAGE_O == ICON_PAGE)) else $error("sweep out of area");
endmodule : drap_asserts
bind drap_top drap_asserts u_chk (.*);

// [sim/drap_ram_model.sv]
`timescale 1ns/1ps
module drap_ram_model (
  input  wire logic       clk_i,
  input  wire logic       valid_i,
  input  wire logic       write_i,
  input  wire logic [3:0] page_i,
  input  wire logic [7:0] col_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       slow_i,
  output wire logic       ready_o,
  output wire logic [7:0] rdata_o
);
  logic [7:0] mem [16][256];
  logic [1:0] wait_q = 2'h0;
  logic [7:0] last_q = 8'h00;
  // Slow mode makes every request wait two cycles
  assign ready_o = valid_i && (!slow_i || wait_q == 2'h2);
  // Idle bus shows the inverse of its last value
  assign rdata_o = valid_i ? mem[page_i][col_i] : ~last_q;
  always @(posedge clk_i) begin
    wait_q <= (valid_i && !ready_o) ? wait_q + 2'h1 : 2'h0;
    if (ready_o)
      last_q <= rdata_o;
    if (ready_o && write_i)
      mem[page_i][col_i] <= wdata_i;
  end
endmodule : drap_ram_model

// [sim/drap_top_tb_top.sv]
`timescale 1ns/1ps
module drap_top_tb_top;
  import drap_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hv = 1'b0, dc = 1'b0, rd = 1'b0;
  logic ser = 1'b0, slow = 1'b0, saw_full = 1'b0;
  logic [7:0] hd = 8'h00, rdat, ramc, wdat, col, rrd, last_rd;
  logic [3:0] rpage, page;
  logic rdy, rv, ref_o, rrv, rwr, rready, busy;
  int errors = 0, n_compared = 0, n_ref = 0, cyc = 0;
  drap_top uut (.CORE_CLK_I(clk), .RESET_I(rst), .HOST_VALID_I(hv),
    .HOST_READY_O(rdy), .HOST_DC_I(dc), .HOST_READ_I(rd),
    .HOST_DATA_I(hd), .SERIAL_MODE_I(ser), .HOST_RDATA_O(rdat),
    .HOST_RDATA_VALID_O(rv), .HOST_REFUSED_O(ref_o),
    .RAM_VALID_O(rrv), .RAM_READY_I(rready), .RAM_WRITE_O(rwr),
    .RAM_PAGE_O(rpage), .RAM_COL_O(ramc), .RAM_WDATA_O(wdat),
    .RAM_RDATA_I(rrd), .CLEAR_BUSY_O(busy), .PAGE_O(page),
    .COLUMN_O(col));
  drap_ram_model u_ram (.clk_i(clk), .valid_i(rrv), .write_i(rwr),
    .page_i(rpage), .col_i(ramc), .wdata_i(wdat), .slow_i(slow),
    .ready_o(rready), .rdata_o(rrd));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rv === 1'b1)
      last_rd <= rdat;
    if (ref_o === 1'b1)
      n_ref <= n_ref + 1;
    if (cyc == 10000) begin
      errors = errors + 1;
      give_verdict();
    end
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Holds valid up so back-to-back transfers need no gap
  task automatic send(logic d, logic r, logic [7:0] v);
    dc = d;
    rd = r;
    hd = v;
    hv = 1'b1;
    while (rdy !== 1'b1) begin
      saw_full = 1'b1;
      @(posedge clk) #1;
    end
    @(posedge clk) #1;
  endtask : send
  task automatic quiet();
    int n;
    n = 0;
    hv = 1'b0;
    while (n < 6) begin
      @(posedge clk) #1;
      n = (rrv !== 1'b0 || busy !== 1'b0) ? 0 : n + 1;
    end
  endtask : quiet
  task automatic addr(logic [3:0] p, logic [7:0] c);
    send(1'b0, 1'b0, {4'h0, p});
    send(1'b0, 1'b0, {7'h13, c[7]});
    send(1'b0, 1'b0, {1'b1, c[6:0]});
  endtask : addr
  task automatic t_reset(int n);
    rst = 1'b1;
    repeat (n) @(posedge clk) #1;
    rst = 1'b0;
    @(posedge clk) #1;
    chk("page", 8'h00, {4'h0, page});
    chk("column", 8'h00, col);
    $display("test reset done");
  endtask : t_reset
  task automatic t_wrap();
    logic [7:0] ex [4] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4};
    addr(4'h2, 8'h9e);
    quiet();
    chk("col set", 8'h9e, col);
    slow = 1'b1;
    saw_full = 1'b0;
    foreach (ex[i]) send(1'b1, 1'b0, ex[i]);
    quiet();
    chk("full", 8'h01, {7'h00, saw_full});
    chk("col wrap", 8'h02, col);
    chk("page kept", 8'h02, {4'h0, page});
    send(1'b0, 1'b0, 8'h27);
    send(1'b0, 1'b0, 8'h9e);
    foreach (ex[i]) begin
      send(1'b1, 1'b1, 8'h00);
      quiet();
      chk("read", ex[i], last_rd);
    end
    chk("col read", 8'h02, col);
    slow = 1'b0;
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_refuse();
    int n0;
    n0 = n_ref;
    send(1'b0, 1'b0, 8'h02);
    send(1'b0, 1'b1, 8'h00);
    quiet();
    chk("cmd read", 8'h01, 8'(n_ref - n0));
    chk("col cmd", 8'h02, col);
    ser = 1'b1;
    send(1'b1, 1'b1, 8'h00);
    send(1'b1, 1'b0, 8'he5);
    quiet();
    chk("ser read", 8'h02, 8'(n_ref - n0));
    chk("ser col", 8'h03, col);
    ser = 1'b0;
    send(1'b0, 1'b0, 8'h34);
    send(1'b0, 1'b0, 8'h85);
    quiet();
    chk("col moved", 8'h05, col);
    send(1'b0, 1'b0, 8'h35);
    quiet();
    chk("col restore", 8'h03, col);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_clear();
    addr(4'h3, 8'h05);
    send(1'b1, 1'b0, 8'h77);
    send(1'b0, 1'b0, CMD_CLR_GFX);
    send(1'b1, 1'b0, 8'h55);
    quiet();
    chk("dummy col", 8'h06, col);
    addr(4'h3, 8'h05);
    send(1'b1, 1'b1, 8'h00);
    quiet();
    chk("gfx clear", CLEAR_DATA, last_rd);
    addr(ICON_PAGE, 8'h07);
    send(1'b1, 1'b0, 8'h88);
    send(1'b0, 1'b0, CMD_CLR_ICON);
    send(1'b1, 1'b0, 8'h99);
    quiet();
    chk("icon col", 8'h08, col);
    send(1'b0, 1'b0, 8'h87);
    send(1'b1, 1'b1, 8'h00);
    quiet();
    chk("icon clear", CLEAR_DATA, last_rd);
    $display("test clear done");
  endtask : t_clear
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    t_reset(16);
    t_wrap();
    t_refuse();
    t_clear();
    t_reset(2);
    give_verdict();
  end
endmodule : drap_top_tb_top

// [src/drap_pkg.sv]
// Notes on behaviour
// RULE_01 - Each data byte read or written moves the column pointer on by one; a command byte never moves it. Column and restore commands set it here.
// RULE_02 - A read in command mode is invalid, returns nothing and leaves the column pointer alone.
// RULE_03 - The first data write after a clear command is a dummy trigger and does not move the column pointer.
// RULE_04 - A column pointer stepping past its top value wraps round instead of saturating or changing page.
// RULE_05 - The host sends page, column-MSB and low-column commands, in that order, before the data bytes.
// RULE_06 - Page and column settings hold until changed, so an address command already in place may be skipped.
// RULE_07 - The clear-page command followed by one dummy data write clears the whole 160 x 64 graphic area.
// RULE_08 - Page 9, the icon-clear command and one dummy data write clear all 160 icon bits.
// RULE_09 - RAM reads and writes are taken in every display mode, even while the content is on the panel.
// RULE_10 - The low column command gives seven address bits, joined to the MSB from the column-MSB command.
// RULE_11 - With the serial host port, data reads from the RAM are not supported; only writes work.
// RULE_12 - A transfer with data/command select high is RAM data, and with it low is a command byte.
// RULE_13 - With 160 columns to a page, the column pointer wraps from 159 back to 0.
// RULE_14 - After reset the page and column pointers are zero and no dummy write is pending.
package drap_pkg;

  localparam int DATA_W    = 8;
  localparam int PAGE_W    = 4;
  localparam int COL_W     = 8;
  localparam int COL_LO_W  = 7;
  localparam int BUF_DEPTH = 2;
  localparam int CNT_W     = 2;

  localparam logic [COL_W-1:0]  COL_RESET     = 8'h00;
  localparam logic [COL_W-1:0]  COL_LAST      = 8'h9f;
  localparam logic [COL_W-1:0]  COL_ONE       = 8'h01;
  localparam logic [PAGE_W-1:0] PAGE_RESET    = 4'h0;
  localparam logic [PAGE_W-1:0] PAGE_ONE      = 4'h1;
  localparam logic [PAGE_W-1:0] GFX_PAGE_LAST = 4'h7;
  localparam logic [PAGE_W-1:0] ICON_PAGE     = 4'h9;
  localparam logic [DATA_W-1:0] CLEAR_DATA    = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_FULL      = 2'h2;
  localparam logic [CNT_W-1:0]  CNT_EMPTY     = 2'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE       = 2'h1;

  localparam logic [DATA_W-1:0] CMD_PAGE_MASK = 8'hf0;
  localparam logic [DATA_W-1:0] CMD_PAGE_VAL  = 8'h00;
  localparam logic [DATA_W-1:0] CMD_MSB_MASK  = 8'hfe;
  localparam logic [DATA_W-1:0] CMD_MSB_VAL   = 8'h26;
  localparam logic [DATA_W-1:0] CMD_SAVE_MASK = 8'hfe;
  localparam logic [DATA_W-1:0] CMD_SAVE_VAL  = 8'h34;
  localparam logic [DATA_W-1:0] CMD_CLR_GFX   = 8'h36;
  localparam logic [DATA_W-1:0] CMD_CLR_ICON  = 8'h37;
  localparam int                CMD_COL_BIT   = 7;
  localparam int                CMD_ARG_BIT   = 0;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CLEAR
  } drap_state_type;

endpackage : drap_pkg

// [src/drap_top.sv]
`timescale 1ns/1ps
module drap_top (
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        RESET_I,
  input  wire logic                        HOST_VALID_I,
  output wire logic                        HOST_READY_O,
  input  wire logic                        HOST_DC_I,
  input  wire logic                        HOST_READ_I,
  input  wire logic [drap_pkg::DATA_W-1:0] HOST_DATA_I,
  input  wire logic                        SERIAL_MODE_I,
  output logic      [drap_pkg::DATA_W-1:0] HOST_RDATA_O,
  output logic                             HOST_RDATA_VALID_O,
  output logic                             HOST_REFUSED_O,
  output wire logic                        RAM_VALID_O,
  input  wire logic                        RAM_READY_I,
  output logic                             RAM_WRITE_O,
  output logic      [drap_pkg::PAGE_W-1:0] RAM_PAGE_O,
  output logic      [drap_pkg::COL_W-1:0]  RAM_COL_O,
  output logic      [drap_pkg::DATA_W-1:0] RAM_WDATA_O,
  input  wire logic [drap_pkg::DATA_W-1:0] RAM_RDATA_I,
  output wire logic                        CLEAR_BUSY_O,
  output wire logic [drap_pkg::PAGE_W-1:0] PAGE_O,
  output wire logic [drap_pkg::COL_W-1:0]  COLUMN_O
);
  import drap_pkg::*;

  // Two-entry buffer between host port and sequencer
  logic [DATA_W-1:0]    buf_data_q [BUF_DEPTH];
  logic                 buf_dc_q   [BUF_DEPTH];
  logic                 buf_rd_q   [BUF_DEPTH];
  logic                 wr_ptr_q;
  logic                 rd_ptr_q;
  logic [CNT_W-1:0]     cnt_q;

  // Address state
  logic [PAGE_W-1:0]    page_q;
  logic [COL_W-1:0]     col_q;
  logic [COL_W-1:0]     col_d;
  logic [COL_W-1:0]     saved_col_q;
  logic                 pend_gfx_q;
  logic                 pend_icon_q;

  // Clear sweep
  drap_state_type       st_q;
  logic                 clr_icon_q;
  logic [PAGE_W-1:0]    clr_page_q;
  logic [COL_W-1:0]     clr_col_q;

  // RAM request
  logic                 req_q;
  logic                 req_read_q;

  wire                  push;
  wire                  pop;
  wire                  buf_valid;
  wire [DATA_W-1:0]     head_data;
  wire                  head_dc;
  wire                  head_rd;
  wire                  take;
  wire                  cmd_wr;
  wire                  cmd_rd;
  wire                  dat;
  wire                  dat_rd_bad;
  wire                  dat_ok;
  wire                  dummy;
  wire                  ram_access;
  wire                  op_page;
  wire                  op_msb;
  wire                  op_col;
  wire                  op_save;
  wire                  op_restore;
  wire                  op_clr_gfx;
  wire                  op_clr_icon;
  wire [COL_W-1:0]      col_inc;
  wire                  sweep_issue;
  wire                  sweep_last_col;
  wire                  sweep_last;
  wire                  issue;
  wire                  req_done;
  wire [PAGE_W-1:0]     iss_page;
  wire [COL_W-1:0]      iss_col;
  wire [DATA_W-1:0]     iss_data;
  wire                  iss_read;

  assign HOST_READY_O = (cnt_q != CNT_FULL);
  assign push         = HOST_VALID_I && HOST_READY_O;
  assign buf_valid    = (cnt_q != CNT_EMPTY);
  assign head_data    = buf_data_q[rd_ptr_q];
  assign head_dc      = buf_dc_q[rd_ptr_q];
  assign head_rd      = buf_rd_q[rd_ptr_q];

  // One entry at a time keeps commands and data in host order
  assign take = buf_valid && (st_q == ST_IDLE) && !req_q; // [RULE_09]
  assign pop  = take;

  assign cmd_wr     = take && !head_dc && !head_rd;         // [RULE_12]
  assign cmd_rd     = take && !head_dc && head_rd;          // [RULE_02]
  assign dat        = take && head_dc;                      // [RULE_12]
  assign dat_rd_bad = dat && head_rd && SERIAL_MODE_I;      // [RULE_11]
  assign dat_ok     = dat && !dat_rd_bad;
  assign dummy      = dat_ok && !head_rd
                      && (pend_gfx_q || pend_icon_q);       // [RULE_03]
  assign ram_access = dat_ok && !dummy;

  assign op_page     = cmd_wr
                       && ((head_data & CMD_PAGE_MASK) == CMD_PAGE_VAL);
  assign op_msb      = cmd_wr
                       && ((head_data & CMD_MSB_MASK) == CMD_MSB_VAL);
  assign op_col      = cmd_wr && head_data[CMD_COL_BIT];
  assign op_save     = cmd_wr
                       && ((head_data & CMD_SAVE_MASK) == CMD_SAVE_VAL)
                       && !head_data[CMD_ARG_BIT];
  assign op_restore  = cmd_wr
                       && ((head_data & CMD_SAVE_MASK) == CMD_SAVE_VAL)
                       && head_data[CMD_ARG_BIT];
  assign op_clr_gfx  = cmd_wr && (head_data == CMD_CLR_GFX);
  assign op_clr_icon = cmd_wr && (head_data == CMD_CLR_ICON);

  // Also catches columns set above the top by the low command
  assign col_inc = (col_q >= COL_LAST) ? COL_RESET
                                       : col_q + COL_ONE; // [RULE_04] [RULE_13]

  always_comb begin
    col_d = col_q; // [RULE_06]
    if (ram_access) begin
      col_d = col_inc; // [RULE_01]
    end else if (op_col) begin
      col_d = {col_q[COL_W-1], head_data[COL_LO_W-1:0]}; // [RULE_10]
    end else if (op_msb) begin
      col_d = {head_data[CMD_ARG_BIT], col_q[COL_LO_W-1:0]}; // [RULE_10]
    end else if (op_restore) begin
      col_d = saved_col_q;
    end
  end

  assign sweep_issue    = (st_q == ST_CLEAR) && !req_q;
  assign sweep_last_col = (clr_col_q == COL_LAST);
  assign sweep_last     = sweep_last_col
                          && (clr_icon_q || (clr_page_q == GFX_PAGE_LAST));

  assign issue    = ram_access || sweep_issue;
  assign iss_page = sweep_issue ? clr_page_q : page_q;
  assign iss_col  = sweep_issue ? clr_col_q : col_q;
  assign iss_data = sweep_issue ? CLEAR_DATA : head_data;
  assign iss_read = !sweep_issue && head_rd;
  assign req_done = req_q && RAM_READY_I;

  assign RAM_VALID_O  = req_q;
  assign CLEAR_BUSY_O = (st_q == ST_CLEAR);
  assign PAGE_O       = page_q;
  assign COLUMN_O     = col_q;

  genvar gi;
  generate
    for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_entry
      always_ff @(posedge CORE_CLK_I) begin
        if (push && (wr_ptr_q == 1'(gi))) begin
          buf_data_q[gi] <= HOST_DATA_I;
          buf_dc_q[gi]   <= HOST_DC_I;
          buf_rd_q[gi]   <= HOST_READ_I;
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= CNT_EMPTY;
    end else begin
      if (push) wr_ptr_q <= !wr_ptr_q;
      if (pop)  rd_ptr_q <= !rd_ptr_q;
      if (push && !pop)      cnt_q <= cnt_q + CNT_ONE;
      else if (pop && !push) cnt_q <= cnt_q - CNT_ONE;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      page_q      <= PAGE_RESET; // [RULE_14]
      col_q       <= COL_RESET;  // [RULE_14]
      saved_col_q <= COL_RESET;
    end else begin
      col_q <= col_d;
      if (op_page) page_q <= head_data[PAGE_W-1:0]; // [RULE_05]
      if (op_save) saved_col_q <= col_q;
    end
  end

  // A new clear command replaces any clear still waiting for its trigger
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      pend_gfx_q  <= 1'b0; // [RULE_14]
      pend_icon_q <= 1'b0; // [RULE_14]
    end else if (op_clr_gfx || op_clr_icon) begin
      pend_gfx_q  <= op_clr_gfx;
      pend_icon_q <= op_clr_icon;
    end else if (dummy) begin
      pend_gfx_q  <= 1'b0;
      pend_icon_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      st_q       <= ST_IDLE;
      clr_icon_q <= 1'b0;
      clr_page_q <= PAGE_RESET;
      clr_col_q  <= COL_RESET;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (dummy) begin
            st_q       <= ST_CLEAR;
            clr_icon_q <= pend_icon_q;                         // [RULE_08]
            clr_page_q <= pend_icon_q ? ICON_PAGE : PAGE_RESET; // [RULE_07]
            clr_col_q  <= COL_RESET;
          end
        end
        ST_CLEAR: begin
          if (sweep_issue) begin
            if (sweep_last) begin
              st_q <= ST_IDLE;
            end else if (sweep_last_col) begin
              clr_col_q  <= COL_RESET;
              clr_page_q <= clr_page_q + PAGE_ONE; // [RULE_07]
            end else begin
              clr_col_q <= clr_col_q + COL_ONE; // [RULE_07] [RULE_08]
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Request holds its fields until the RAM side takes it
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      req_q       <= 1'b0;
      req_read_q  <= 1'b0;
      RAM_WRITE_O <= 1'b0;
      RAM_PAGE_O  <= PAGE_RESET;
      RAM_COL_O   <= COL_RESET;
      RAM_WDATA_O <= CLEAR_DATA;
    end else if (issue) begin
      req_q       <= 1'b1;
      req_read_q  <= iss_read;
      RAM_WRITE_O <= !iss_read;
      RAM_PAGE_O  <= iss_page;
      RAM_COL_O   <= iss_col;
      RAM_WDATA_O <= iss_data;
    end else if (req_done) begin
      req_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      HOST_RDATA_O       <= CLEAR_DATA;
      HOST_RDATA_VALID_O <= 1'b0;
      HOST_REFUSED_O     <= 1'b0;
    end else begin
      HOST_RDATA_VALID_O <= req_done && req_read_q;
      HOST_REFUSED_O     <= cmd_rd || dat_rd_bad; // [RULE_02] [RULE_11]
      if (req_done && req_read_q) HOST_RDATA_O <= RAM_RDATA_I;
    end
  end

endmodule : drap_top
